// >>> hdl/i2c_supervisor.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
module i2c_supervisor
   import i2c_supervisor_pkg::*;
#(
   parameter int unsigned SL_CYC  = SHORT_LOW_CYC,
   parameter int unsigned SH0_CYC = SH_CODE0_CYC,
   parameter int unsigned SH1_CYC = SH_CODE1_CYC,
   parameter int unsigned SH2_CYC = SH_CODE2_CYC,
   parameter int unsigned SH3_CYC = SH_CODE3_CYC,
   parameter int unsigned LLU_CYC = LL_UNIT_CYC
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        scl_drive_req,
   input  wire logic        sda_drive_req,
   output logic             scl_out,
   output logic             scl_oe,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             i2c_logic_rst,
   output logic [6:0]       target_addr,
   output link_cfg_t        link_cfg,
   output logic             crc_en,
   output logic             thermistor_pin_disable,
   output logic             bus_busy,
   output logic             irq
);
   // ---- register storage
   logic [6:0]        target_addr_field_r;
   logic [6:0]        target_addr_field_nxt;
   link_cfg_t         cfg_r;
   link_cfg_t         cfg_nxt;
   logic              therm_r;
   logic              therm_nxt;
   logic [NUM_EV-1:0] sts_r;
   logic [NUM_EV-1:0] sts_nxt;
   logic [NUM_EV-1:0] mask_r;
   logic [NUM_EV-1:0] mask_nxt;
   logic [31:0]       rdata_r;
   logic [31:0]       rdata_nxt;
   logic              err_r;
   logic              err_nxt;

   // ---- pin synchronisers, bit 1 scl, bit 0 sda
   logic [1:0] s1_r;
   logic [1:0] s2_r;
   logic [1:0] s3_r;
   logic [1:0] filt_r;
   logic [1:0] filt_nxt;
   logic       scl_s;
   logic       sda_s;
   logic       sda_prev_r;

   // ---- bus monitor
   bus_state_t        state_r;
   bus_state_t        state_nxt;
   logic              rst_pulse_r;
   logic              rst_pulse_nxt;
   logic [NUM_EV-1:0] to_cond;
   logic [LIM_W-1:0]  to_lim [NUM_EV];
   logic [NUM_EV-1:0] to_fire;
   logic              any_fire;
   logic              start_det;
   logic              stop_det;
   logic [LIM_W-1:0]  sh_lim;
   logic [LIM_W-1:0]  ll_lim;
   logic              wr_acc;
   logic              rd_setup;

   // ---- apb decode; zero wait states, read data fetched in setup
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && err_r;
   assign prdata   = rdata_r;
   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   always_comb begin
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
      if (rd_setup) begin
         err_nxt   = 1'b0;
         rdata_nxt = 32'h0000_0000;
         case (paddr)
            OFS_ADDR:     rdata_nxt[6:0] = target_addr_field_r;
            OFS_CFG:      rdata_nxt[15:0] = cfg_r;
            OFS_THERM:    rdata_nxt[0] = therm_r;
            OFS_IRQ_STS:  rdata_nxt[NUM_EV-1:0] = sts_r;
            OFS_IRQ_MASK: rdata_nxt[NUM_EV-1:0] = mask_r;
            OFS_STATE:    rdata_nxt[9:0] = {target_addr, bus_busy, scl_s, sda_s};
            default:      err_nxt = 1'b1;
         endcase
      end
   end

   // register writes; hardware set of a status bit beats a w1c
   always_comb begin
      target_addr_field_nxt = target_addr_field_r;
      cfg_nxt               = cfg_r;
      therm_nxt             = therm_r;
      mask_nxt              = mask_r;
      sts_nxt               = sts_r;
      if (wr_acc) begin
         case (paddr)
            OFS_ADDR:     target_addr_field_nxt = pwdata[6:0];
            OFS_CFG:      cfg_nxt = pwdata[15:0] & CFG_WMASK;
            OFS_THERM:    therm_nxt = pwdata[0];
            OFS_IRQ_STS:  sts_nxt = sts_r & ~pwdata[NUM_EV-1:0];
            OFS_IRQ_MASK: mask_nxt = pwdata[NUM_EV-1:0];
            default:      ;
         endcase
      end
      sts_nxt = sts_nxt | to_fire;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         target_addr_field_r <= RST_ADDR[6:0];
         cfg_r               <= RST_CFG;
         therm_r             <= RST_THERM[0];
         sts_r               <= '0;
         mask_r              <= '0;
         rdata_r             <= 32'h0000_0000;
         err_r               <= 1'b0;
      end else begin
         target_addr_field_r <= target_addr_field_nxt;
         cfg_r               <= cfg_nxt;
         therm_r             <= therm_nxt;
         sts_r               <= sts_nxt;
         mask_r              <= mask_nxt;
         rdata_r             <= rdata_nxt;
         err_r               <= err_nxt;
      end
   end

   // effective address, zero falls back to the fixed address
   assign target_addr = (target_addr_field_r == 7'h00) ? FALLBACK_ADDR
                                                       : target_addr_field_r;
   assign link_cfg               = cfg_r;
   assign crc_en                 = cfg_r.crc_en;
   assign thermistor_pin_disable = therm_r;
   assign irq                    = |(sts_r & mask_r);

   // per line: a change is accepted once stages two and three agree on it,
   // so a move of scl never holds back a move of sda and start stays visible
   always_comb begin
      filt_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r       <= 2'h3;
         s2_r       <= 2'h3;
         s3_r       <= 2'h3;
         filt_r     <= 2'h3;
         sda_prev_r <= 1'b1;
      end else begin
         s1_r       <= {scl_in, sda_in};
         s2_r       <= s1_r;
         s3_r       <= s2_r;
         filt_r     <= filt_nxt;
         sda_prev_r <= filt_r[0];
      end
   end

   assign scl_s = filt_r[1];
   assign sda_s = filt_r[0];

   // start and stop are sda edges while scl stays high
   assign start_det = scl_s && sda_prev_r && !sda_s;
   assign stop_det  = scl_s && !sda_prev_r && sda_s;

   // duration selection for the timeout channels
   always_comb begin
      case (cfg_r.clk_short_high_duration)
         2'h0:    sh_lim = LIM_W'(SH0_CYC);
         2'h1:    sh_lim = LIM_W'(SH1_CYC);
         2'h2:    sh_lim = LIM_W'(SH2_CYC);
         default: sh_lim = LIM_W'(SH3_CYC);
      endcase
   end

   // code zero gives a zero limit, which the counter treats as off
   assign ll_lim = LIM_W'(LIM_W'(cfg_r.long_low_duration) * LIM_W'(LLU_CYC));

   // short-high only during a transaction, an idle bus rests high
   assign to_cond[EV_SHORT_LOW]  = cfg_r.clk_short_low_to_en && !scl_s;
   assign to_cond[EV_SHORT_HIGH] = cfg_r.clk_short_high_to_en && scl_s
                                   && state_r == BUS_BUSY;
   assign to_cond[EV_LONG_LOW]   = !scl_s && (!cfg_r.long_low_cond_sel || !sda_s);
   assign to_cond[EV_BUS_BUSY]   = cfg_r.bus_busy_to_en && state_r == BUS_BUSY;
   assign to_lim[EV_SHORT_LOW]   = LIM_W'(SL_CYC);
   assign to_lim[EV_SHORT_HIGH]  = sh_lim;
   assign to_lim[EV_LONG_LOW]    = ll_lim;
   assign to_lim[EV_BUS_BUSY]    = ll_lim;

   // one supervising counter per timeout source
   genvar gi;
   generate
      for (gi = 0; gi < NUM_EV; gi++) begin : g_to
         timeout_counter #(
            .W (LIM_W)
         ) u_to (
            .clk     (clk),
            .sys_rst (sys_rst),
            .cond    (to_cond[gi]),
            .limit   (to_lim[gi]),
            .fire    (to_fire[gi])
         );
      end
   endgenerate

   assign any_fire = |to_fire;

   // transaction tracking; a timeout forces idle and resets the engine
   always_comb begin
      state_nxt     = state_r;
      rst_pulse_nxt = any_fire;
      case (state_r)
         BUS_IDLE: begin
            if (start_det) begin
               state_nxt = BUS_BUSY;
            end
         end
         BUS_BUSY: begin
            if (stop_det) begin
               state_nxt = BUS_IDLE;
            end
         end
         default: state_nxt = BUS_IDLE;
      endcase
      if (any_fire) begin
         state_nxt = BUS_IDLE;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r     <= BUS_IDLE;
         rst_pulse_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         rst_pulse_r <= rst_pulse_nxt;
      end
   end

   assign bus_busy      = state_r == BUS_BUSY;
   assign i2c_logic_rst = rst_pulse_r;

   // open drain; drive low only on request and never during reset pulse
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = scl_drive_req && !rst_pulse_r;
   assign sda_oe  = sda_drive_req && !rst_pulse_r;

   // helpers for checks: cycles scl low, cycles scl high inside a transaction
   logic [31:0] scl_low_cnt_r;
   logic [31:0] sh_busy_cnt_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_low_cnt_r <= '0;
         sh_busy_cnt_r <= '0;
      end else begin
         scl_low_cnt_r <= scl_s ? 32'h0 : scl_low_cnt_r + {31'h0, ~&scl_low_cnt_r};
         sh_busy_cnt_r <= (scl_s && bus_busy) ? sh_busy_cnt_r + 32'h1 : 32'h0;
      end
   end

   sequence cfg_write_s;
      psel && penable && pwrite && paddr == OFS_CFG;
   endsequence
   sequence timeout_s;
      any_fire;
   endsequence
   sequence released_s;
      rst_pulse_r && !scl_oe && !sda_oe && state_r == BUS_IDLE;
   endsequence

   chk_addr_fallback: assert property (
      @(posedge clk) disable iff (sys_rst)
      target_addr_field_r == 7'h00 |-> target_addr == 7'h08)
      else $error("zero address field did not map to 0x08");
   chk_addr_direct: assert property (
      @(posedge clk) disable iff (sys_rst)
      target_addr_field_r != 7'h00 |-> target_addr == target_addr_field_r)
      else $error("nonzero address field not used directly");
   chk_short_low_time: assert property (
      @(posedge clk) disable iff (sys_rst)
      to_fire[EV_SHORT_LOW] |-> cfg_r.clk_short_low_to_en && !scl_s
                                && scl_low_cnt_r >= SL_CYC - 1)
      else $error("short-low timeout fired early or disabled");
   chk_short_high_en: assert property (
      @(posedge clk) disable iff (sys_rst)
      to_fire[EV_SHORT_HIGH] |-> cfg_r.clk_short_high_to_en && scl_s)
      else $error("short-high timeout fired while disabled or scl low");
   chk_short_high_dur: assert property (
      @(posedge clk) disable iff (sys_rst)
      to_fire[EV_SHORT_HIGH] |-> sh_busy_cnt_r + 32'h1 >=
         (cfg_r.clk_short_high_duration == 2'h0 ? SH0_CYC :
          cfg_r.clk_short_high_duration == 2'h1 ? SH1_CYC :
          cfg_r.clk_short_high_duration == 2'h2 ? SH2_CYC : SH3_CYC))
      else $error("short-high timeout fired before its selected duration");
   chk_long_low_cond: assert property (
      @(posedge clk) disable iff (sys_rst)
      to_fire[EV_LONG_LOW] |-> !scl_s && (!cfg_r.long_low_cond_sel || !sda_s))
      else $error("long-low timeout fired on wrong line condition");
   chk_long_low_off: assert property (
      @(posedge clk) disable iff (sys_rst)
      cfg_r.long_low_duration == 3'h0 |-> !to_fire[EV_LONG_LOW]
                                          && !to_fire[EV_BUS_BUSY])
      else $error("long-low timer fired with duration code zero");
   chk_bus_busy_en: assert property (
      @(posedge clk) disable iff (sys_rst)
      to_fire[EV_BUS_BUSY] |-> cfg_r.bus_busy_to_en && state_r == BUS_BUSY)
      else $error("bus-busy timeout fired outside an enabled transaction");
   chk_crc_update: assert property (
      @(posedge clk) disable iff (sys_rst)
      cfg_write_s |=> crc_en == $past(pwdata[0]))
      else $error("crc enable did not follow config write");
   chk_timeout_release: assert property (
      @(posedge clk) disable iff (sys_rst)
      timeout_s |=> released_s ##1 (!rst_pulse_r || $past(any_fire)))
      else $error("timeout did not release lines and idle the receiver");
   chk_status_sticky: assert property (
      @(posedge clk) disable iff (sys_rst)
      to_fire[EV_SHORT_LOW] |=> sts_r[EV_SHORT_LOW])
      else $error("timeout event lost in status register");
endmodule

// >>> hdl/i2c_supervisor_pkg.sv
package i2c_supervisor_pkg;

   // register byte offsets on the APB
   localparam logic [7:0] OFS_ADDR     = 8'h00;
   localparam logic [7:0] OFS_CFG      = 8'h04;
   localparam logic [7:0] OFS_THERM    = 8'h08;
   localparam logic [7:0] OFS_IRQ_STS  = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_STATE    = 8'h14;

   // reset values
   localparam logic [7:0]  RST_ADDR  = 8'h08;
   localparam logic [15:0] RST_CFG   = 16'h3400;
   localparam logic [7:0]  RST_THERM = 8'h00;
   localparam logic [6:0]  FALLBACK_ADDR = 7'h08;

   // writable bits of the link config word
   localparam logic [15:0] CFG_WMASK = 16'hFF03;

   // interrupt status bit positions
   localparam int unsigned EV_SHORT_LOW  = 0;
   localparam int unsigned EV_SHORT_HIGH = 1;
   localparam int unsigned EV_LONG_LOW   = 2;
   localparam int unsigned EV_BUS_BUSY   = 3;
   localparam int unsigned NUM_EV        = 4;

   // timing
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned SHORT_LOW_MS  = 25;
   localparam int unsigned SH_CODE0_MS   = 64;
   localparam int unsigned SH_CODE1_MS   = 512;
   localparam int unsigned SH_CODE2_MS   = 1;
   localparam int unsigned SH_CODE3_MS   = 15;
   localparam int unsigned LL_UNIT_MS    = 500;
   localparam int unsigned SHORT_LOW_CYC = SHORT_LOW_MS * CYC_PER_MS;
   localparam int unsigned SH_CODE0_CYC  = SH_CODE0_MS * CYC_PER_MS;
   localparam int unsigned SH_CODE1_CYC  = SH_CODE1_MS * CYC_PER_MS;
   localparam int unsigned SH_CODE2_CYC  = SH_CODE2_MS * CYC_PER_MS;
   localparam int unsigned SH_CODE3_CYC  = SH_CODE3_MS * CYC_PER_MS;
   localparam int unsigned LL_UNIT_CYC   = LL_UNIT_MS * CYC_PER_MS;

   // timeout counter width, holds 7 x 0.5 s at 50 MHz
   localparam int unsigned LIM_W = 28;

   // serial link configuration word
   typedef struct packed {
      logic       clk_short_low_to_en;
      logic       clk_short_high_to_en;
      logic [1:0] clk_short_high_duration;
      logic       long_low_cond_sel;
      logic [2:0] long_low_duration;
      logic [5:0] rsvd;
      logic       bus_busy_to_en;
      logic       crc_en;
   } link_cfg_t;

   // bus monitor states
   typedef enum logic {BUS_IDLE, BUS_BUSY} bus_state_t;

endpackage

// >>> hdl/timeout_counter.sv
module timeout_counter
   import i2c_supervisor_pkg::*;
#(
   parameter int unsigned W = LIM_W
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output logic              fire
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // saturates at the limit so one stretch of cond fires once
   always_comb begin
      cnt_nxt = cnt_r;
      if (!cond || limit == '0) begin
         cnt_nxt = '0;
      end else if (cnt_r != limit) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // pulse in the cycle cond has held for limit cycles
   assign fire = cond && (limit != '0) && (cnt_r == limit - 1'b1);
endmodule

// >>> tb/i2c_host_model.sv
module i2c_host_model (
   input  wire logic clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   timeunit 1ns;
   timeprecision 1ps;

   logic scl_low_r;
   logic sda_low_r;

   // wired-and with pull-ups: a released line always rests high
   assign scl = !(scl_low_r || scl_oe);
   assign sda = !(sda_low_r || sda_oe);

   initial begin
      scl_low_r = 1'b0;
      sda_low_r = 1'b0;
   end

   // host moves its lines just after a rising edge
   task automatic set_lines(input logic s, input logic d);
      @(posedge clk);
      scl_low_r <= !s;
      sda_low_r <= !d;
   endtask

   // start: sda falls while scl high; hold long enough to pass the filter
   task automatic start_cond();
      set_lines(1'b1, 1'b1);
      repeat (4) @(posedge clk);
      set_lines(1'b1, 1'b0);
   endtask

   // stop: sda rises while scl high
   task automatic stop_cond();
      set_lines(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      set_lines(1'b1, 1'b1);
      repeat (4) @(posedge clk);
   endtask
endmodule

// >>> tb/i2c_supervisor_tb.sv
module i2c_supervisor_tb
   import i2c_supervisor_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // short counts keep the run small; expectations derive from these
   localparam int SL  = 30;
   localparam int LLU = 24;
   localparam int SLK = 10;
   int            sh_lim [4] = '{40, 80, 20, 60};

   logic        clk = 1'b0;
   logic        sys_rst, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err;
   logic        scl, sda, scl_drive_req, sda_drive_req, scl_oe, sda_oe;
   logic        i2c_logic_rst, crc_en, thermistor_pin_disable, bus_busy, irq;
   logic [6:0]  target_addr;
   link_cfg_t   link_cfg;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          n;
   logic [7:0]  a_in  [4] = '{8'h00, 8'h01, 8'h55, 8'h7F};
   logic [7:0]  a_exp [4] = '{8'h08, 8'h01, 8'h55, 8'h7F};

   always #10 clk = ~clk;

   i2c_supervisor #(.SL_CYC(SL), .SH0_CYC(40), .SH1_CYC(80), .SH2_CYC(20),
      .SH3_CYC(60), .LLU_CYC(LLU)) dut (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
      .scl_drive_req(scl_drive_req), .sda_drive_req(sda_drive_req),
      .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
      .i2c_logic_rst(i2c_logic_rst), .target_addr(target_addr),
      .link_cfg(link_cfg), .crc_en(crc_en),
      .thermistor_pin_disable(thermistor_pin_disable), .bus_busy(bus_busy),
      .irq(irq));

   i2c_host_model host (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no wait-state count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 32'h1, {31'h0, pready});
   endtask

   task automatic settle();
      repeat (2) @(negedge clk);
   endtask

   // counts cycles until the engine reset pulse, sampled mid-cycle
   task automatic wait_fire(input int max, output int cnt);
      cnt = 0;
      @(negedge clk);
      while (i2c_logic_rst !== 1'b1 && cnt < max) begin
         @(negedge clk);
         cnt++;
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      #1_000_000;
      chk("watchdog", 32'h0, 32'h1);
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      scl_drive_req = 1'b0;
      sda_drive_req = 1'b0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, OFS_ADDR, 32'h0);
      chk("addr reset", 32'h08, rd); // reset value
      apb(1'b0, OFS_CFG, 32'h0);
      chk("cfg reset", 32'h3400, rd); // defaults
      chk("link_cfg", 32'h3400, {16'h0, link_cfg}); // defaults
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped err", 32'h1, err);
      $display("test reset done");
      // every address class: zero, low, mid, top
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_ADDR, {24'h0, a_in[i]});
         settle();
         chk("target_addr", {24'h0, a_exp[i]}, {25'h0, target_addr}); // addr
      end
      apb(1'b0, OFS_STATE, 32'h0);
      chk("state word", 32'h0000_03FB, rd); // addr 0x7F, idle, lines high
      apb(1'b1, OFS_CFG, 32'hFFFF);
      apb(1'b0, OFS_CFG, 32'h0);
      chk("cfg rw", 32'hFF03, rd); // reserved bits read 0
      chk("crc on", 32'h1, {31'h0, crc_en}); // crc mode
      apb(1'b1, OFS_CFG, 32'h0);
      apb(1'b1, OFS_THERM, 32'h1);
      settle();
      chk("crc off", 32'h0, {31'h0, crc_en}); // crc mode
      chk("therm", 32'h1, {31'h0, thermistor_pin_disable});
      $display("test config done");
      // short-low off: no reset however long scl stays low
      host.set_lines(1'b0, 1'b1);
      wait_fire(80, n);
      chk_rng("short-low off", 80, 80, n); // disabled
      host.set_lines(1'b1, 1'b1);
      apb(1'b1, OFS_CFG, 32'h8000);
      host.set_lines(1'b0, 1'b1);
      sda_drive_req <= 1'b1;
      scl_drive_req <= 1'b1;
      settle();
      chk("sda held", 32'h1, {31'h0, sda_oe}); // driven before timeout
      wait_fire(80, n);
      chk_rng("short-low time", SL - 1, SL + SLK, n); // fires
      chk("sda released", 32'h0, {31'h0, sda_oe}); // release
      chk("scl released", 32'h0, {31'h0, scl_oe}); // release
      @(posedge clk);
      sda_drive_req <= 1'b0;
      scl_drive_req <= 1'b0;
      host.set_lines(1'b1, 1'b1);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      chk("sts short-low", 32'h1, rd); // event
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      settle();
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, OFS_IRQ_STS, 32'h1);
      settle();
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test short-low done");
      // every short-high code; idle-high bus only counts once busy
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, OFS_CFG, {16'h0, 2'b01, 2'(c), 12'h000});
         host.start_cond();
         wait_fire(200, n);
         chk_rng("short-high time", sh_lim[c], sh_lim[c] + SLK, n); // code
         chk("busy dropped", 32'h0, {31'h0, bus_busy}); // to idle
         host.stop_cond();
      end
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      chk("sts short-high", 32'h2, rd); // event
      apb(1'b1, OFS_IRQ_STS, 32'hF);
      $display("test short-high done");
      // every long-low code, scl alone
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, OFS_CFG, {20'h0, 1'b0, 3'(c), 8'h00});
         host.set_lines(1'b0, 1'b1);
         wait_fire(200, n);
         if (c == 0) chk_rng("long-low off", 200, 200, n); // code 0
         else chk_rng("long-low time", c * LLU, c * LLU + SLK, n); // half steps
         host.set_lines(1'b1, 1'b1);
         repeat (4) @(posedge clk);
      end
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      chk("sts long-low", 32'h4, rd); // event
      apb(1'b1, OFS_IRQ_STS, 32'hF);
      // both-low condition: scl low alone must not fire
      apb(1'b1, OFS_CFG, 32'h0900);
      host.set_lines(1'b0, 1'b1);
      wait_fire(60, n);
      chk_rng("scl alone", 60, 60, n); // select
      host.set_lines(1'b0, 1'b0);
      wait_fire(60, n);
      chk_rng("both low", LLU, LLU + SLK, n); // select
      host.stop_cond();
      $display("test long-low done");
      // bus-busy: clocked transfer outlasting code 2 (2 x LLU)
      apb(1'b1, OFS_IRQ_STS, 32'hF);
      apb(1'b1, OFS_IRQ_MASK, 32'h8);
      apb(1'b1, OFS_CFG, 32'h0202);
      host.start_cond();
      for (int i = 0; i < 15; i++) begin
         host.set_lines(1'b0, 1'b0);
         repeat (2) @(posedge clk);
         host.set_lines(1'b1, 1'b0);
         repeat (2) @(posedge clk);
         if (i == 4) begin
            @(negedge clk);
            chk("busy mid", 32'h1, {31'h0, bus_busy}); // in transfer
            chk("no early fire", 32'h0, {31'h0, irq}); // not yet
         end
      end
      host.stop_cond();
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      chk("sts bus-busy", 32'h8, rd); // fires
      chk("irq bus-busy", 32'h1, {31'h0, irq}); // fires
      apb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk("mask rw", 32'h8, rd);
      $display("test bus-busy done");
      final_report();
   end
endmodule
